// File: verilog/sec_pkg.sv
package sec_pkg;
    // register map, byte addresses on the plain register port
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_ADDR_LO = 8'h08;
    localparam logic [7:0] OFS_ADDR_HI = 8'h0c;
    localparam logic [7:0] OFS_INT_STS = 8'h10;
    localparam logic [7:0] OFS_INT_CLR = 8'h14;
    localparam logic [7:0] OFS_INT_EN = 8'h18;
    // eeprom_command_reg field positions
    localparam int unsigned CMD_BUSY_BIT = 31;
    localparam int unsigned CMD_OP_LSB = 28;
    localparam int unsigned CMD_RLD_BIT = 10;
    localparam int unsigned CMD_TO_BIT = 9;
    localparam int unsigned CMD_LOADED_BIT = 8;
    // interrupt status bits
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_DONE = 0;
    localparam int unsigned IRQ_TO = 1;
    localparam int unsigned IRQ_LOADED = 2;
    // auto-load
    localparam logic [7:0] SIGNATURE = 8'ha5;
    localparam logic [2:0] SIG_IDX = 3'h0;
    localparam logic [2:0] LAST_IDX = 3'h6;
    // serial frame
    localparam int unsigned FRAME_W = 18;
    localparam logic [4:0] SHORT_LAST = 5'h09;
    localparam logic [4:0] LONG_LAST = 5'h11;
    localparam logic START_BIT = 1'b1;
    localparam logic [1:0] SER_READ = 2'b10;
    localparam logic [1:0] SER_WRITE = 2'b01;
    localparam logic [1:0] SER_ERASE = 2'b11;
    localparam logic [1:0] SER_EXT = 2'b00;
    localparam logic [1:0] EXT_UNLOCK = 2'b11;
    localparam logic [1:0] EXT_LOCK = 2'b00;
    localparam logic [1:0] EXT_ERASE_ALL = 2'b10;
    localparam logic [1:0] EXT_WRITE_ALL = 2'b01;
    // timing at the 40 MHz device clock
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned TIMEOUT_MS = 30;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int unsigned SCLK_HALF_NS = 500;
    localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ) / 1000;

    typedef enum logic [2:0] {
        op_read = 3'h0,
        erase_write_lock_op = 3'h1,
        erase_write_unlock_op = 3'h2,
        op_write = 3'h3,
        write_all_op = 3'h4,
        op_erase = 3'h5,
        erase_all_op = 3'h6,
        op_reload = 3'h7
    } sec_op_t;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_shift = 3'b001,
        st_gap = 3'b011,
        st_poll = 3'b010,
        st_done = 3'b110
    } sec_state_t;

    typedef struct packed {
        logic chip_select;
        logic serial_mem_clock;
        logic data_to_mem;
    } sec_pins_t;

    typedef struct packed {
        logic cmd_busy_flag;
        sec_op_t cmd_opcode_field;
        logic reload_done_flag;
        logic cmd_timeout_flag;
        logic addr_loaded_flag;
        logic [6:0] cmd_location_field;
    } sec_cmd_t;
endpackage

// File: verilog/sec_sync.sv
`timescale 1ns/10ps
module sec_sync
#(
    parameter int unsigned W = 1
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous level in, synchronised level out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_ff <= '0;
            q_ff <= '0;
        end
        else
        begin
            meta_ff <= d_i;
            q_ff <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule // sec_sync

// File: verilog/sec_tick.sv
`timescale 1ns/10ps
module sec_tick
#(
    parameter int unsigned DIV = 20
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // one-cycle enable every DIV clocks
    output logic tick_o
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_ff;
    logic tick_ff;
    wire wrap = (cnt_ff == LAST);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
            tick_ff <= wrap;
        end
    end

    assign tick_o = tick_ff;
endmodule // sec_tick

// File: verilog/sec_ctrl.sv
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module sec_ctrl
#(
    parameter int unsigned TIMEOUT_CYCLES = sec_pkg::TIMEOUT_CYC,
    parameter int unsigned TO_W = 21,
    parameter int unsigned SCLK_DIV = sec_pkg::SCLK_HALF_CYC
)
(
    // clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // interrupt
    output logic irq_o,
    // station address to the mac
    output logic [47:0] station_addr_o,
    // serial memory pins
    output sec_pkg::sec_pins_t pins_o,
    input wire logic mem_dout_i
);
    import sec_pkg::*;

    sec_state_t state_ff, nxt_state;
    sec_cmd_t cmd_ff;
    logic [7:0] data_ff;
    logic [47:0] station_ff;
    logic [IRQ_W-1:0] sts_ff, en_ff;
    logic loading_ff, nxt_loading;
    logic boot_ff, nxt_boot;
    logic [2:0] idx_ff, nxt_idx;
    logic [FRAME_W-1:0] tx_ff, nxt_tx;
    logic [7:0] rx_ff, nxt_rx;
    logic [4:0] bit_cnt_ff, nxt_bit_cnt;
    logic sclk_ff, nxt_sclk;
    logic cs_ff, nxt_cs;
    logic [TO_W-1:0] to_cnt_ff, nxt_to_cnt;
    logic timed_out_ff, nxt_timed_out;
    logic [31:0] rdata_ff;
    logic irq_ff;
    logic din_s;
    logic tick;

    sec_sync #(.W(1)) u_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(mem_dout_i),
        .q_o(din_s)
    );

    sec_tick #(.DIV(SCLK_DIV)) u_tick
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // register port decode
    wire sel_cmd = (addr_i == OFS_CMD);
    wire cmd_wr = wr_i && sel_cmd && !cmd_ff.cmd_busy_flag;
    wire sec_op_t wr_op = sec_op_t'(wdata_i[CMD_OP_LSB +: 3]);
    wire cmd_go = cmd_wr && wdata_i[CMD_BUSY_BIT];
    wire reload_go = cmd_go && (wr_op == op_reload);
    wire data_wr = wr_i && (addr_i == OFS_DATA);
    wire lo_wr = wr_i && (addr_i == OFS_ADDR_LO);
    wire hi_wr = wr_i && (addr_i == OFS_ADDR_HI);
    wire clr_wr = wr_i && (addr_i == OFS_INT_CLR);
    wire en_wr = wr_i && (addr_i == OFS_INT_EN);

    // operation now running: the auto-load always reads
    wire sec_op_t run_op = loading_ff ? op_read : cmd_ff.cmd_opcode_field;
    wire [6:0] run_loc = loading_ff ? {4'h0, idx_ff} : cmd_ff.cmd_location_field;
    wire is_read = (run_op == op_read);
    wire is_write = (run_op == op_write);
    wire is_erase = (run_op == op_erase);
    wire long_op = is_read || is_write || (run_op == write_all_op);
    wire needs_poll = is_write || is_erase || (run_op == write_all_op) || (run_op == erase_all_op);
    wire [1:0] ser_op = is_read ? SER_READ : is_write ? SER_WRITE : is_erase ? SER_ERASE : SER_EXT;
    wire [1:0] ext_sel = (run_op == erase_write_unlock_op) ? EXT_UNLOCK :
                         (run_op == erase_all_op) ? EXT_ERASE_ALL :
                         (run_op == write_all_op) ? EXT_WRITE_ALL : EXT_LOCK;
    wire [6:0] ser_adr = (ser_op == SER_EXT) ? {ext_sel, run_loc[4:0]} : run_loc;
    wire [FRAME_W-1:0] frame = {START_BIT, ser_op, ser_adr, data_ff};
    wire [4:0] last_bit = long_op ? LONG_LAST : SHORT_LAST;
    wire launch = loading_ff || cmd_ff.cmd_busy_flag;
    wire to_hit = (to_cnt_ff == TO_W'(TIMEOUT_CYCLES - 1));
    wire settled = (to_cnt_ff >= TO_W'(SCLK_DIV));

    // outcome of a finished frame
    wire fin = (state_ff == st_done);
    wire sig_bad = loading_ff && (idx_ff == SIG_IDX) && (rx_ff != SIGNATURE);
    wire store_byte = fin && loading_ff && (idx_ff != SIG_IDX) && !sig_bad;
    wire load_ok = fin && loading_ff && (idx_ff == LAST_IDX) && !sig_bad;
    wire load_end = fin && loading_ff && (sig_bad || (idx_ff == LAST_IDX));
    wire host_end = fin && !loading_ff;
    wire store_data = host_end && is_read && !timed_out_ff;
    wire ev_to = (state_ff == st_poll) && to_hit && !din_s;
    wire [2:0] byte_sel = idx_ff - 3'h1;
    wire [IRQ_W-1:0] ev_vec = {load_ok, ev_to, (host_end || load_end)};

    // serial engine and load sequencing
    always_comb
    begin
        nxt_state = state_ff;
        nxt_loading = loading_ff;
        nxt_boot = boot_ff;
        nxt_idx = idx_ff;
        nxt_tx = tx_ff;
        nxt_rx = rx_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_sclk = sclk_ff;
        nxt_cs = cs_ff;
        nxt_to_cnt = to_cnt_ff;
        nxt_timed_out = timed_out_ff;
        case (state_ff)
            st_idle:
            begin
                if (launch)
                begin
                    nxt_state = st_shift;
                    nxt_tx = frame;
                    nxt_rx = 8'h00;
                    nxt_bit_cnt = 5'h00;
                    nxt_sclk = 1'b0;
                    nxt_cs = 1'b1;
                    nxt_timed_out = 1'b0;
                end
            end
            st_shift:
            begin
                if (tick)
                begin
                    nxt_sclk = !sclk_ff;
                    if (sclk_ff)
                    begin
                        nxt_rx = {rx_ff[6:0], din_s};
                        nxt_tx = {tx_ff[FRAME_W-2:0], 1'b0};
                        nxt_bit_cnt = bit_cnt_ff + 5'h01;
                        if (bit_cnt_ff == last_bit)
                        begin
                            nxt_state = st_gap;
                            nxt_cs = 1'b0;
                        end
                    end
                end
            end
            st_gap:
            begin
                if (tick)
                begin
                    nxt_state = needs_poll ? st_poll : st_done;
                    nxt_cs = needs_poll;
                    nxt_to_cnt = '0;
                end
            end
            st_poll:
            begin
                nxt_to_cnt = to_cnt_ff + 1'b1;
                if ((din_s && settled) || to_hit)
                begin
                    nxt_state = st_done;
                    nxt_cs = 1'b0;
                    nxt_timed_out = !din_s;
                end
            end
            st_done:
            begin
                nxt_state = st_idle;
                if (load_end)
                begin
                    nxt_loading = 1'b0;
                    nxt_boot = 1'b0;
                end
                else if (loading_ff)
                begin
                    nxt_idx = idx_ff + 3'h1;
                end
            end
            default:
            begin
                nxt_state = st_idle;
                nxt_cs = 1'b0;
                nxt_sclk = 1'b0;
            end
        endcase
        if (reload_go)
        begin
            nxt_loading = 1'b1;
            nxt_boot = 1'b0;
            nxt_idx = SIG_IDX;
        end
        if (soft_rst_i)
        begin
            nxt_state = st_idle;
            nxt_loading = 1'b1;
            nxt_boot = 1'b1;
            nxt_idx = SIG_IDX;
            nxt_cs = 1'b0;
            nxt_sclk = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff <= st_idle;
            loading_ff <= 1'b1;
            boot_ff <= 1'b1;
            idx_ff <= 3'h0;
            tx_ff <= '0;
            rx_ff <= 8'h00;
            bit_cnt_ff <= 5'h00;
            sclk_ff <= 1'b0;
            cs_ff <= 1'b0;
            to_cnt_ff <= '0;
            timed_out_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            loading_ff <= nxt_loading;
            boot_ff <= nxt_boot;
            idx_ff <= nxt_idx;
            tx_ff <= nxt_tx;
            rx_ff <= nxt_rx;
            bit_cnt_ff <= nxt_bit_cnt;
            sclk_ff <= nxt_sclk;
            cs_ff <= nxt_cs;
            to_cnt_ff <= nxt_to_cnt;
            timed_out_ff <= nxt_timed_out;
        end
    end

    // command register: busy set by host, cleared by the controller
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmd_ff <= '{cmd_busy_flag: 1'b1, cmd_opcode_field: op_read, default: '0};
        end
        else if (soft_rst_i)
        begin
            cmd_ff.cmd_busy_flag <= 1'b1;
            cmd_ff.addr_loaded_flag <= 1'b0;
        end
        else
        begin
            if (cmd_wr)
            begin
                cmd_ff.cmd_busy_flag <= wdata_i[CMD_BUSY_BIT];
                cmd_ff.cmd_opcode_field <= wr_op;
                cmd_ff.cmd_location_field <= wdata_i[6:0];
            end
            else if (host_end || load_end)
            begin
                cmd_ff.cmd_busy_flag <= 1'b0;
            end
            if (reload_go)
            begin
                cmd_ff.addr_loaded_flag <= 1'b0;
            end
            else if (load_ok)
            begin
                cmd_ff.addr_loaded_flag <= 1'b1;
            end
            cmd_ff.cmd_timeout_flag <= ev_to || (cmd_ff.cmd_timeout_flag && !(cmd_wr && wdata_i[CMD_TO_BIT]));
            cmd_ff.reload_done_flag <= (load_ok && !boot_ff) ||
                (cmd_ff.reload_done_flag && !(cmd_wr && wdata_i[CMD_RLD_BIT]));
        end
    end

    // data register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            data_ff <= 8'h00;
        else if (store_data)
            data_ff <= rx_ff;
        else if (data_wr)
            data_ff <= wdata_i[7:0];
    end

    // station address, byte 0 at the bottom of the low word
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            station_ff <= '0;
        else if (store_byte)
            station_ff[8 * byte_sel +: 8] <= rx_ff;
        else if (lo_wr)
            station_ff[31:0] <= wdata_i;
        else if (hi_wr)
            station_ff[47:32] <= wdata_i[15:0];
    end

    // sticky status: an event in the clearing cycle wins
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sts_ff <= '0;
            en_ff <= '0;
            irq_ff <= 1'b0;
        end
        else
        begin
            sts_ff <= ev_vec | (sts_ff & ~(clr_wr ? wdata_i[IRQ_W-1:0] : '0));
            if (en_wr)
                en_ff <= wdata_i[IRQ_W-1:0];
            irq_ff <= |(sts_ff & en_ff);
        end
    end

    // read data mux, answered the cycle after the strobe
    wire [31:0] cmd_word = {cmd_ff.cmd_busy_flag, cmd_ff.cmd_opcode_field, 17'h0_0000,
        cmd_ff.reload_done_flag, cmd_ff.cmd_timeout_flag, cmd_ff.addr_loaded_flag, 1'b0,
        cmd_ff.cmd_location_field};
    wire [31:0] rd_mux = sel_cmd ? cmd_word :
                         (addr_i == OFS_DATA) ? {24'h00_0000, data_ff} :
                         (addr_i == OFS_ADDR_LO) ? station_ff[31:0] :
                         (addr_i == OFS_ADDR_HI) ? {16'h0000, station_ff[47:32]} :
                         (addr_i == OFS_INT_STS) ? {29'h0000_0000, sts_ff} :
                         (addr_i == OFS_INT_EN) ? {29'h0000_0000, en_ff} : 32'h0000_0000;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_ff <= 32'h0000_0000;
        else
            rdata_ff <= rd_i ? rd_mux : 32'h0000_0000;
    end

    assign rdata_o = rdata_ff;
    assign irq_o = irq_ff;
    assign station_addr_o = station_ff;
    assign pins_o.chip_select = cs_ff;
    assign pins_o.serial_mem_clock = sclk_ff;
    assign pins_o.data_to_mem = tx_ff[FRAME_W-1];
endmodule // sec_ctrl

// File: bench/sec_properties.sv
`timescale 1ns/10ps
module sec_properties
(
    // clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic soft_rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic irq_o,
    input wire logic [47:0] station_addr_o,
    // serial memory pins
    input wire sec_pkg::sec_pins_t pins_o,
    input wire logic mem_dout_i
);
    import sec_pkg::*;
    logic sclk_q_ff;
    logic [4:0] rise_cnt_ff;
    logic sclk_rise;
    assign sclk_rise = pins_o.serial_mem_clock && !sclk_q_ff;
    // serial clock rises counted inside one chip select period
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sclk_q_ff <= 1'b0;
            rise_cnt_ff <= 5'h0;
        end
        else
        begin
            sclk_q_ff <= pins_o.serial_mem_clock;
            rise_cnt_ff <= pins_o.chip_select ? rise_cnt_ff + {4'h0, sclk_rise} : 5'h0;
        end
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_sclk_idle;
        !pins_o.chip_select |-> !pins_o.serial_mem_clock;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock outside frame");
    property p_cs_held;
        $rose(pins_o.serial_mem_clock) |-> pins_o.chip_select && $past(pins_o.chip_select);
    endproperty
    a_cs_held: assert property (p_cs_held) else $error("select not held");
    property p_start_bit;
        sclk_rise && rise_cnt_ff == 5'h0 |-> pins_o.data_to_mem == START_BIT;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit");
    property p_clk_count;
        $fell(pins_o.chip_select) |-> rise_cnt_ff inside {5'h00, 5'h0a, 5'h12};
    endproperty
    a_clk_count: assert property (p_clk_count) else $error("bad clock count");
    property p_soft_abort;
        soft_rst_i |=> !pins_o.chip_select && !pins_o.serial_mem_clock;
    endproperty
    a_soft_abort: assert property (p_soft_abort) else $error("soft reset kept frame");
    property p_rdata_idle;
        !$past(rd_i) |-> rdata_o == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
    property p_addr_write;
        wr_i && addr_i == OFS_ADDR_LO && !pins_o.chip_select |=> station_addr_o[31:0] == $past(wdata_i);
    endproperty
    a_addr_write: assert property (p_addr_write) else $error("host address lost");
    property p_irq_mask;
        rd_i && addr_i == OFS_INT_EN ##1 rdata_o[IRQ_W-1:0] == '0 |-> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
endmodule // sec_properties

// File: bench/sec_mem_model.sv
`timescale 1ns/10ps
module sec_mem_model
#(
    parameter int READY_CYC = 40
)
(
    // clock
    input wire logic clk_i,
    // controller pins and a stuck-busy control
    input wire sec_pkg::sec_pins_t pins_i,
    input wire logic stall_i,
    // memory data out
    output logic mem_dout_o
);
    import sec_pkg::*;
    logic [7:0] mem [128] = '{default: 8'hff};
    logic [17:0] sr = '0;
    logic [6:0] loc = '0;
    logic [1:0] op = '0;
    logic unlocked = 1'b0;
    logic sclk_q = 1'b0;
    logic drive = 1'b0;
    logic dval = 1'b0;
    int nbit = 0;
    int busy = 0;
    initial mem_dout_o = 1'b0;
    always @(posedge clk_i)
    begin
        if (busy > 0 && !stall_i)
            busy = busy - 1;
        if (!pins_i.chip_select)
        begin
            nbit = 0;
            drive = 1'b0;
        end
        else if (pins_i.serial_mem_clock && !sclk_q)
        begin
            sr = {sr[16:0], pins_i.data_to_mem};
            nbit = (nbit == 0 && !pins_i.data_to_mem) ? 0 : nbit + 1;
            if (nbit == 10)
            begin
                op = sr[8:7];
                loc = sr[6:0];
                drive = (op == SER_READ);
                dval = 1'b0;
                if (op == SER_EXT && loc[6:5] == EXT_UNLOCK)
                    unlocked = 1'b1;
                if (op == SER_EXT && loc[6:5] == EXT_LOCK)
                    unlocked = 1'b0;
                if (unlocked && op == SER_ERASE)
                    mem[loc] = 8'hff;
                if (unlocked && op == SER_EXT && loc[6:5] == EXT_ERASE_ALL)
                    mem = '{default: 8'hff};
                if (unlocked && (op == SER_ERASE || (op == SER_EXT && loc[6:5] == EXT_ERASE_ALL)))
                    busy = READY_CYC;
            end
            if (nbit > 10 && op == SER_READ)
                dval = mem[loc][18-nbit];
            if (nbit == 18 && unlocked && op == SER_WRITE)
                mem[loc] = sr[7:0];
            if (nbit == 18 && unlocked && op == SER_EXT && loc[6:5] == EXT_WRITE_ALL)
                mem = '{default: sr[7:0]};
            if (nbit == 18 && unlocked && op != SER_READ)
                busy = READY_CYC;
        end
        else if (nbit == 0)
        begin
            drive = 1'b1;
            dval = (busy == 0);
        end
        sclk_q = pins_i.serial_mem_clock;
        // released line shows a changing pattern
        mem_dout_o <= drive ? dval : ~mem_dout_o;
    end
endmodule // sec_mem_model

// File: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import sec_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic soft_rst_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic stall = 1'b0;
    logic [31:0] rdata_o;
    logic irq_o;
    logic [47:0] station_addr_o;
    sec_pins_t pins_o;
    logic mem_dout_i;
    logic [31:0] rv;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #12.5 clk_i = ~clk_i;
    sec_ctrl #(.TIMEOUT_CYCLES(300), .TO_W(21), .SCLK_DIV(4)) DUT
    (
        .clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .station_addr_o(station_addr_o),
        .pins_o(pins_o), .mem_dout_i(mem_dout_i)
    );
    sec_mem_model #(.READY_CYC(40)) MEM (.clk_i(clk_i), .pins_i(pins_o), .stall_i(stall), .mem_dout_o(mem_dout_i));
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
    endtask
    task automatic wait_idle;
        int n = 0;
        rd(OFS_CMD);
        while (rv[CMD_BUSY_BIT] !== 1'b0 && n < 2000)
        begin
            rd(OFS_CMD);
            n++;
        end
        chk("busy", 48'h0, {47'h0, rv[CMD_BUSY_BIT]});
    endtask
    task automatic cmd(input sec_op_t op, input logic [6:0] loc);
        wr(OFS_CMD, {1'b1, op, 21'h0, loc});
        rd(OFS_CMD);
        chk("busy set", 48'h1, {47'h0, rv[CMD_BUSY_BIT]});
        wait_idle();
    endtask
    task automatic t_boot;
        rd(OFS_CMD);
        chk("boot busy", 48'h1, {47'h0, rv[CMD_BUSY_BIT]});
        wait_idle();
        chk("station", 48'h1615_1413_1211, station_addr_o);
        rd(OFS_ADDR_LO);
        chk("addr low", 48'h1413_1211, {16'h0, rv});
        rd(OFS_CMD);
        chk("loaded", 48'h1, {47'h0, rv[CMD_LOADED_BIT]});
        rd(8'h1c);
        chk("unmapped", 48'h0, {16'h0, rv});
    endtask
    task automatic t_rw;
        cmd(erase_write_unlock_op, 7'h00);
        wr(OFS_DATA, 32'h0000_003c);
        cmd(op_write, 7'h7f);
        chk("mem write", 48'h3c, {40'h0, MEM.mem[127]});
        wr(OFS_DATA, 32'h0000_0000);
        cmd(op_read, 7'h7f);
        rd(OFS_DATA);
        chk("read", 48'h3c, {16'h0, rv});
        cmd(op_erase, 7'h7f);
        chk("erase", 48'hff, {40'h0, MEM.mem[127]});
        cmd(erase_write_lock_op, 7'h00);
        wr(OFS_DATA, 32'h0000_0011);
        cmd(op_write, 7'h7f);
        chk("locked", 48'hff, {40'h0, MEM.mem[127]});
        cmd(erase_write_unlock_op, 7'h00);
        cmd(erase_all_op, 7'h00);
        chk("erase all", 48'hff, {40'h0, MEM.mem[3]});
    endtask
    task automatic t_timeout;
        stall <= 1'b1;
        cmd(op_erase, 7'h10);
        stall <= 1'b0;
        rd(OFS_CMD);
        chk("timeout", 48'h1, {47'h0, rv[CMD_TO_BIT]});
        rd(OFS_INT_STS);
        chk("status", 48'h7, {45'h0, rv[2:0]});
        rd(OFS_INT_EN);
        chk("irq masked", 48'h0, {47'h0, irq_o});
        wr(OFS_INT_EN, 32'h0000_0002);
        @(posedge clk_i);
        #1 chk("irq on", 48'h1, {47'h0, irq_o});
        wr(OFS_INT_CLR, 32'h0000_0002);
        @(posedge clk_i);
        #1 chk("irq off", 48'h0, {47'h0, irq_o});
        wr(OFS_CMD, 32'h0000_0200);
        rd(OFS_CMD);
        chk("timeout clear", 48'h0, {47'h0, rv[CMD_TO_BIT]});
    endtask
    task automatic t_reload;
        wr(OFS_DATA, 32'h0000_005a);
        cmd(write_all_op, 7'h00);
        cmd(op_reload, 7'h00);
        rd(OFS_CMD);
        chk("reload fail", 48'h0, {45'h0, rv[10:8]});
        chk("station kept", 48'h1615_1413_1211, station_addr_o);
        wr(OFS_DATA, 32'h0000_00a5);
        cmd(op_write, 7'h00);
        cmd(op_reload, 7'h00);
        rd(OFS_CMD);
        chk("reload ok", 48'h5, {45'h0, rv[10:8]});
        chk("station new", 48'h5a5a_5a5a_5a5a, station_addr_o);
    endtask
    task automatic t_soft;
        wr(OFS_ADDR_LO, 32'h89ab_0123);
        wr(OFS_ADDR_HI, 32'h0000_4567);
        wr(OFS_DATA, 32'h0000_0000);
        cmd(op_write, 7'h00);
        @(posedge clk_i);
        soft_rst_i <= 1'b1;
        @(posedge clk_i);
        soft_rst_i <= 1'b0;
        wait_idle();
        rd(OFS_CMD);
        chk("soft no load", 48'h0, {47'h0, rv[CMD_LOADED_BIT]});
        chk("soft station", 48'h4567_89ab_0123, station_addr_o);
    endtask
    initial
    begin
        MEM.mem[0] = 8'ha5;
        for (int i = 1; i < 7; i++)
            MEM.mem[i] = 8'h10 + 8'(i);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_boot();
        t_rw();
        t_timeout();
        t_reload();
        t_soft();
        test_done();
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            test_done();
        end
    end
endmodule // tb_top
bind sec_ctrl sec_properties u_props
(
    .clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .station_addr_o(station_addr_o),
    .pins_o(pins_o), .mem_dout_i(mem_dout_i)
);
